//--- tcc_chk.sv
`timescale 1ns/1ps
module tcc_chk (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic TIMER_OUTPUT_PIN,
    input wire logic FIRST_CAPTURE_INTERRUPT,
    input wire logic SECOND_CAPTURE_INTERRUPT
);
    logic wr_reg;
    logic [7:0] addr_reg;
    logic [1:0] mode_reg;
    logic [7:0] stop_reg;
    wire taken = HSEL && HTRANS[1] && HREADY;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // Shadow of the mode field and saturating time spent stopped
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wr_reg <= 1'b0;
            addr_reg <= 8'h00;
            mode_reg <= 2'h0;
            stop_reg <= 8'h00;
        end else begin
            wr_reg <= taken && HWRITE;
            addr_reg <= HADDR[7:0];
            if (wr_reg && addr_reg == tcc_pkg::ADDR_MODE) begin
                mode_reg <= HWDATA[3:2];
            end
            stop_reg <= (mode_reg != tcc_pkg::MODE_STOP || wr_reg) ? 8'h00 : stop_reg + {7'h00, stop_reg != 8'hff};
        end
    end
    a_bus_okay: assert property (HREADYOUT && HRESP == tcc_pkg::HRESP_OKAY)
        else $error("bus answer not ready or not okay");
    a_idle_rdata: assert property (!(taken && !HWRITE) |=> HRDATA == 32'h0)
        else $error("read data outside a read");
    a_irq1_pulse: assert property (FIRST_CAPTURE_INTERRUPT |=> !FIRST_CAPTURE_INTERRUPT)
        else $error("first interrupt longer than one cycle");
    a_irq2_pulse: assert property (SECOND_CAPTURE_INTERRUPT |=> !SECOND_CAPTURE_INTERRUPT)
        else $error("second interrupt longer than one cycle");
    a_stop_quiet1: assert property (stop_reg == 8'hff |-> !FIRST_CAPTURE_INTERRUPT)
        else $error("first interrupt while stopped");
    a_stop_quiet2: assert property (stop_reg == 8'hff |-> !SECOND_CAPTURE_INTERRUPT)
        else $error("second interrupt while stopped");
    a_stop_pin: assert property (stop_reg == 8'hff && !wr_reg && !$past(wr_reg) |-> $stable(TIMER_OUTPUT_PIN))
        else $error("output moved while stopped");
    a_mode_rdata: assert property (taken && !HWRITE && HADDR[7:0] == tcc_pkg::ADDR_MODE && stop_reg == 8'hff
        && !wr_reg |=> HRDATA[3:2] == tcc_pkg::MODE_STOP)
        else $error("mode reads wrong while stopped");
    c_first: cover property ($rose(FIRST_CAPTURE_INTERRUPT));
    c_second: cover property ($rose(SECOND_CAPTURE_INTERRUPT));
    c_stop_read: cover property (stop_reg == 8'hff && taken);
endmodule
bind tcc_timer tcc_chk chk (.SYS_CLK(SYS_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .FIRST_CAPTURE_INTERRUPT(FIRST_CAPTURE_INTERRUPT),
    .SECOND_CAPTURE_INTERRUPT(SECOND_CAPTURE_INTERRUPT));

//--- tcc_edge_filter.sv
`timescale 1ns/1ps
module tcc_edge_filter (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    input wire logic sample,
    input wire logic enable,
    input wire logic [1:0] edge_sel,
    output logic valid_edge,
    output logic reverse_edge
);
    logic sync1_reg;
    logic sync2_reg;
    logic last_reg;
    logic last_next;
    logic level_reg;
    logic level_next;
    logic seen_reg;
    logic seen_next;
    logic change;
    logic rise;
    logic fall;

    // Two samples in a row at the new level accept it
    always_comb begin
        last_next = sample ? sync2_reg : last_reg;
        change = sample && (sync2_reg == last_reg) && (sync2_reg != level_reg);
        seen_next = seen_reg | enable;
        // Level stays low until first enable, so a high pin reads as rising
        if (change && (enable || seen_reg)) begin
            level_next = sync2_reg;
        end else begin
            level_next = level_reg;
        end
        rise = enable && change && sync2_reg;
        fall = enable && change && !sync2_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg <= 1'b0;
            level_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
            last_reg <= last_next;
            level_reg <= level_next;
            seen_reg <= seen_next;
        end
    end

    // Edge classification, silent while stopped
    always_comb begin
        case (edge_sel)
            tcc_pkg::EDGE_FALL: begin
                valid_edge = fall;
                reverse_edge = rise;
            end
            tcc_pkg::EDGE_RISE: begin
                valid_edge = rise;
                reverse_edge = fall;
            end
            tcc_pkg::EDGE_BOTH: begin
                valid_edge = rise | fall;
                reverse_edge = 1'b0;
            end
            default: begin
                valid_edge = 1'b0;
                reverse_edge = 1'b0;
            end
        endcase
    end
endmodule

//--- tcc_pkg.sv
package tcc_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_PRESCALE = 8'h04;
    localparam logic [7:0] ADDR_CAPCTL = 8'h08;
    localparam logic [7:0] ADDR_EDGE = 8'h0c;
    localparam logic [7:0] ADDR_OUTCTL = 8'h10;
    localparam logic [7:0] ADDR_CC0 = 8'h14;
    localparam logic [7:0] ADDR_CC1 = 8'h18;
    localparam logic [7:0] ADDR_COUNT = 8'h1c;

    // Mode control register fields
    localparam int MODE_OVF_BIT = 0;
    localparam int MODE_SEL_LSB = 2;

    // Mode select encodings
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_CLR_EDGE = 2'h2;
    localparam logic [1:0] MODE_CLR_MATCH = 2'h3;

    // Prescaler select encodings and divide ratios
    localparam logic [1:0] PS_DIV_A = 2'h0;
    localparam logic [1:0] PS_DIV_B = 2'h1;
    localparam logic [1:0] PS_DIV_C = 2'h2;
    localparam logic [1:0] PS_EXT = 2'h3;
    localparam logic [4:0] DIV_A_MASK = 5'h01;
    localparam logic [4:0] DIV_B_MASK = 5'h07;
    localparam logic [4:0] DIV_C_MASK = 5'h1f;

    // Capture control fields
    localparam int CAP_FIRST_BIT = 0;
    localparam int CAP_REVERSE_BIT = 1;
    localparam int CAP_SECOND_BIT = 2;

    // Edge select fields and encodings
    localparam int EDGE_PRI_LSB = 0;
    localparam int EDGE_SEC_LSB = 2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Output control fields
    localparam int OUT_EN_BIT = 0;
    localparam int OUT_TOG0_BIT = 1;
    localparam int OUT_TOG1_BIT = 2;
    localparam int OUT_OS_EN_BIT = 3;
    localparam int OUT_OS_TRIG_BIT = 4;
    localparam int OUT_LVL_SET_BIT = 5;
    localparam int OUT_LVL_RST_BIT = 6;

    // Reset values and counter maximum
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] CC_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [6:0] OUTCTL_RESET = 7'h00;

    // Bus response code
    localparam logic HRESP_OKAY = 1'b0;

endpackage

//--- tcc_prescaler.sv
`timescale 1ns/1ps
module tcc_prescaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] sel,
    input wire logic ext_pulse,
    output logic rise,
    output logic fall
);
    logic [4:0] div_reg;
    logic [4:0] div_next;
    logic ext_dly_reg;
    logic ext_dly_next;
    logic [4:0] mask;

    // Free-running divider, never restarted by timer start
    always_comb begin
        div_next = div_reg + 5'h01;
        ext_dly_next = ext_pulse;
        case (sel)
            tcc_pkg::PS_DIV_A: mask = tcc_pkg::DIV_A_MASK;
            tcc_pkg::PS_DIV_B: mask = tcc_pkg::DIV_B_MASK;
            default: mask = tcc_pkg::DIV_C_MASK;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= 5'h00;
            ext_dly_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            ext_dly_reg <= ext_dly_next;
        end
    end

    // Count clock rising and falling events
    always_comb begin
        if (sel == tcc_pkg::PS_EXT) begin
            rise = ext_pulse;
            fall = ext_dly_reg;
        end else begin
            rise = (div_reg & mask) == mask;
            fall = (div_reg & mask) == (mask >> 1);
        end
    end
endmodule

//--- tcc_timer.sv
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
// Function
// - First match after start may be one count clock late.
// - Capture proceeds during a register read; interrupts only for valid edges.
// - Capture/compare contents are undefined after the timer stops.
// - Clear-on-match at all ones sets the overflow flag on wrap.
// - Overflow flag clear while counter is still zero is ineffective.
// - One-shot pulse only in free-running or clear-on-edge modes.
// - Primary edge as count clock spoils captures triggered by it.
// - Capture on count clock fall; interrupt on following rise.
// - Reverse-phase capture raises no interrupt; secondary edge interrupts without capture.
// - First enable after reset treats a high input as rising edge.
// - Primary filter samples on peripheral clock if count source, else count clock.
// - Valid edge needs the new level on two consecutive samples.
// - Trigger inputs ignored while the timer is stopped.
// - Counter read from a buffer updated on each count-up.
module tcc_timer (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic PRIMARY_TRIGGER_INPUT,
    input wire logic SECONDARY_TRIGGER_INPUT,
    output logic TIMER_OUTPUT_PIN,
    output logic FIRST_CAPTURE_INTERRUPT,
    output logic SECOND_CAPTURE_INTERRUPT
);
    // Bus and register state
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] mode_reg, mode_next;
    logic [1:0] presc_reg, presc_next;
    logic [2:0] capctl_reg, capctl_next;
    logic [3:0] edge_reg, edge_next;
    logic [6:0] outctl_reg, outctl_next;
    logic [15:0] cc0_reg, cc0_next;
    logic [15:0] cc1_reg, cc1_next;
    // Timer state
    logic [15:0] count_reg, count_next;
    logic [15:0] cbuf_reg, cbuf_next;
    logic ovf_reg, ovf_next;
    logic ovf_hold_reg, ovf_hold_next;
    logic clr_pend_reg, clr_pend_next;
    logic cap0_pend_reg, cap0_pend_next;
    logic cap1_pend_reg, cap1_pend_next;
    logic ext0_pend_reg, ext0_pend_next;
    logic irq0_pend_reg, irq0_pend_next;
    logic irq1_pend_reg, irq1_pend_next;
    logic out_reg, out_next;
    logic os_armed_reg, os_armed_next;
    logic irq0_reg, irq0_next;
    logic irq1_reg, irq1_next;
    // Combinational helpers
    logic addr_phase, data_wr, running, tick, fall_tick, pri_is_clock;
    logic pri_valid, pri_reverse, sec_valid, pri_sample;
    logic match0, match1, wrap, os_trig, os_mode;
    logic [15:0] count_inc;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign running = mode_reg != tcc_pkg::MODE_STOP;
    assign pri_is_clock = presc_reg == tcc_pkg::PS_EXT;
    assign pri_sample = pri_is_clock ? 1'b1 : tick;

    // Input filters, gated while stopped
    tcc_edge_filter u_pri_filter (
        .clk(SYS_CLK),
        .rst(RST),
        .pin(PRIMARY_TRIGGER_INPUT),
        .sample(pri_sample),
        .enable(running),
        .edge_sel(edge_reg[tcc_pkg::EDGE_PRI_LSB +: 2]),
        .valid_edge(pri_valid),
        .reverse_edge(pri_reverse)
    );

    tcc_edge_filter u_sec_filter (
        .clk(SYS_CLK),
        .rst(RST),
        .pin(SECONDARY_TRIGGER_INPUT),
        .sample(tick),
        .enable(running),
        .edge_sel(edge_reg[tcc_pkg::EDGE_SEC_LSB +: 2]),
        .valid_edge(sec_valid),
        .reverse_edge()
    );

    // Count clock; divider phase is independent of timer start
    tcc_prescaler u_prescaler (
        .clk(SYS_CLK),
        .rst(RST),
        .sel(presc_reg),
        .ext_pulse(pri_valid),
        .rise(tick),
        .fall(fall_tick)
    );

    // AHB-Lite slave: zero wait, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = tcc_pkg::HRESP_OKAY;
    assign HRDATA = rdata_reg;
    assign addr_phase = HSEL && HTRANS[1] && HREADY;
    assign data_wr = wr_pend_reg;

    // Compare and wrap detection
    always_comb begin
        count_inc = count_reg + 16'h0001;
        match0 = running && tick && (count_reg == cc0_reg) && !capctl_reg[tcc_pkg::CAP_FIRST_BIT];
        match1 = running && tick && (count_reg == cc1_reg) && !capctl_reg[tcc_pkg::CAP_SECOND_BIT];
        wrap = running && tick && (count_reg == tcc_pkg::COUNT_MAX);
        os_mode = (mode_reg == tcc_pkg::MODE_FREE) || (mode_reg == tcc_pkg::MODE_CLR_EDGE);
        os_trig = pri_valid || (data_wr && hit(wr_addr_reg, tcc_pkg::ADDR_OUTCTL) && HWDATA[tcc_pkg::OUT_OS_TRIG_BIT]);
    end

    // Register file and bus next state
    always_comb begin
        wr_pend_next = addr_phase && HWRITE;
        wr_addr_next = addr_phase ? HADDR[7:0] : wr_addr_reg;
        mode_next = mode_reg;
        presc_next = presc_reg;
        capctl_next = capctl_reg;
        edge_next = edge_reg;
        outctl_next = outctl_reg;
        cc0_next = cc0_reg;
        cc1_next = cc1_reg;
        if (data_wr) begin
            if (hit(wr_addr_reg, tcc_pkg::ADDR_MODE)) mode_next = HWDATA[tcc_pkg::MODE_SEL_LSB +: 2];
            if (hit(wr_addr_reg, tcc_pkg::ADDR_PRESCALE)) presc_next = HWDATA[1:0];
            if (hit(wr_addr_reg, tcc_pkg::ADDR_CAPCTL)) capctl_next = HWDATA[2:0];
            if (hit(wr_addr_reg, tcc_pkg::ADDR_EDGE)) edge_next = HWDATA[3:0];
            if (hit(wr_addr_reg, tcc_pkg::ADDR_OUTCTL)) outctl_next = HWDATA[6:0];
            if (hit(wr_addr_reg, tcc_pkg::ADDR_CC0)) cc0_next = HWDATA[15:0];
            if (hit(wr_addr_reg, tcc_pkg::ADDR_CC1)) cc1_next = HWDATA[15:0];
        end
        outctl_next[tcc_pkg::OUT_OS_TRIG_BIT] = 1'b0; // Trigger bit is a strobe
        // Captures override a same-cycle software write
        if (fall_tick && cap0_pend_reg) cc0_next = count_reg;
        if (fall_tick && cap1_pend_reg) cc1_next = count_reg;
        // Stopping leaves the capture/compare contents as they stand, not guaranteed
        rdata_next = 32'h0000_0000;
        if (addr_phase && !HWRITE) begin
            case (HADDR[7:0])
                tcc_pkg::ADDR_MODE: begin
                    rdata_next[tcc_pkg::MODE_SEL_LSB +: 2] = mode_reg;
                    rdata_next[tcc_pkg::MODE_OVF_BIT] = ovf_reg;
                end
                tcc_pkg::ADDR_PRESCALE: rdata_next[1:0] = presc_reg;
                tcc_pkg::ADDR_CAPCTL: rdata_next[2:0] = capctl_reg;
                tcc_pkg::ADDR_EDGE: rdata_next[3:0] = edge_reg;
                tcc_pkg::ADDR_OUTCTL: rdata_next[6:0] = outctl_reg;
                tcc_pkg::ADDR_CC0: rdata_next[15:0] = cc0_reg;
                tcc_pkg::ADDR_CC1: rdata_next[15:0] = cc1_reg;
                tcc_pkg::ADDR_COUNT: rdata_next[15:0] = cbuf_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            mode_reg <= tcc_pkg::MODE_STOP;
            presc_reg <= tcc_pkg::PS_DIV_A;
            capctl_reg <= 3'h0;
            edge_reg <= 4'h0;
            outctl_reg <= tcc_pkg::OUTCTL_RESET;
            cc0_reg <= tcc_pkg::CC_RESET;
            cc1_reg <= tcc_pkg::CC_RESET;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg <= rdata_next;
            mode_reg <= mode_next;
            presc_reg <= presc_next;
            capctl_reg <= capctl_next;
            edge_reg <= edge_next;
            outctl_reg <= outctl_next;
            cc0_reg <= cc0_next;
            cc1_reg <= cc1_next;
        end
    end

    // Counter, read buffer and overflow flag
    always_comb begin
        count_next = count_reg;
        cbuf_next = cbuf_reg;
        clr_pend_next = clr_pend_reg;
        ovf_hold_next = ovf_hold_reg;
        if (!running) begin
            count_next = tcc_pkg::COUNT_RESET;
            clr_pend_next = 1'b0;
            ovf_hold_next = 1'b0;
        end else begin
            if (mode_reg == tcc_pkg::MODE_CLR_EDGE && pri_valid) clr_pend_next = 1'b1;
            if (tick) begin
                if (clr_pend_reg || (mode_reg == tcc_pkg::MODE_CLR_MATCH && count_reg == cc0_reg)) begin
                    count_next = tcc_pkg::COUNT_RESET;
                end else begin
                    count_next = count_inc;
                end
                clr_pend_next = 1'b0;
                cbuf_next = count_next;
                // Flag re-set persists until the counter leaves zero
                ovf_hold_next = wrap && (count_next == tcc_pkg::COUNT_RESET);
            end
        end
        ovf_next = ovf_reg;
        if (data_wr && hit(wr_addr_reg, tcc_pkg::ADDR_MODE) && !HWDATA[tcc_pkg::MODE_OVF_BIT]) ovf_next = 1'b0;
        if ((wrap && count_next == tcc_pkg::COUNT_RESET) || ovf_hold_reg) ovf_next = 1'b1;
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            count_reg <= tcc_pkg::COUNT_RESET;
            cbuf_reg <= tcc_pkg::COUNT_RESET;
            clr_pend_reg <= 1'b0;
            ovf_hold_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            cbuf_reg <= cbuf_next;
            clr_pend_reg <= clr_pend_next;
            ovf_hold_reg <= ovf_hold_next;
            ovf_reg <= ovf_next;
        end
    end

    // Capture requests, taken on count clock fall; interrupts on next rise
    always_comb begin
        cap0_pend_next = cap0_pend_reg;
        cap1_pend_next = cap1_pend_reg;
        ext0_pend_next = ext0_pend_reg;
        irq0_pend_next = irq0_pend_reg;
        irq1_pend_next = irq1_pend_reg;
        if (capctl_reg[tcc_pkg::CAP_FIRST_BIT]) begin
            if (capctl_reg[tcc_pkg::CAP_REVERSE_BIT]) begin
                if (pri_reverse && !pri_is_clock) cap0_pend_next = 1'b1;
                if (sec_valid) ext0_pend_next = 1'b1;
            end else if (sec_valid) begin
                cap0_pend_next = 1'b1;
            end
        end
        if (capctl_reg[tcc_pkg::CAP_SECOND_BIT] && pri_valid && !pri_is_clock) cap1_pend_next = 1'b1;
        if (fall_tick) begin
            // Reverse-phase capture raises no interrupt
            if (cap0_pend_reg && !capctl_reg[tcc_pkg::CAP_REVERSE_BIT]) irq0_pend_next = 1'b1;
            if (ext0_pend_reg) irq0_pend_next = 1'b1;
            if (cap1_pend_reg) irq1_pend_next = 1'b1;
            cap0_pend_next = 1'b0;
            cap1_pend_next = 1'b0;
            ext0_pend_next = 1'b0;
        end
        irq0_next = (tick && irq0_pend_reg) || match0;
        irq1_next = (tick && irq1_pend_reg) || match1;
        if (tick) begin
            irq0_pend_next = 1'b0;
            irq1_pend_next = 1'b0;
        end
        if (!running) begin
            cap0_pend_next = 1'b0;
            cap1_pend_next = 1'b0;
            ext0_pend_next = 1'b0;
            irq0_pend_next = 1'b0;
            irq1_pend_next = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cap0_pend_reg <= 1'b0;
            cap1_pend_reg <= 1'b0;
            ext0_pend_reg <= 1'b0;
            irq0_pend_reg <= 1'b0;
            irq1_pend_reg <= 1'b0;
            irq0_reg <= 1'b0;
            irq1_reg <= 1'b0;
        end else begin
            cap0_pend_reg <= cap0_pend_next;
            cap1_pend_reg <= cap1_pend_next;
            ext0_pend_reg <= ext0_pend_next;
            irq0_pend_reg <= irq0_pend_next;
            irq1_pend_reg <= irq1_pend_next;
            irq0_reg <= irq0_next;
            irq1_reg <= irq1_next;
        end
    end

    assign FIRST_CAPTURE_INTERRUPT = irq0_reg;
    assign SECOND_CAPTURE_INTERRUPT = irq1_reg;

    // Timer output: level set/reset when stopped, toggle and one-shot when running
    always_comb begin
        out_next = out_reg;
        os_armed_next = os_armed_reg;
        if (!running) begin
            os_armed_next = 1'b0;
            if (outctl_reg[tcc_pkg::OUT_LVL_SET_BIT]) out_next = 1'b1;
            else if (outctl_reg[tcc_pkg::OUT_LVL_RST_BIT]) out_next = 1'b0;
        end else if (outctl_reg[tcc_pkg::OUT_OS_EN_BIT]) begin
            if (os_mode) begin
                if (os_trig && !out_reg) os_armed_next = 1'b1;
                if (os_armed_reg && match1) out_next = 1'b1;
                if (out_reg && match0) begin
                    out_next = 1'b0;
                    os_armed_next = 1'b0;
                end
            end
        end else begin
            if (outctl_reg[tcc_pkg::OUT_TOG0_BIT] && match0) out_next = !out_next;
            if (outctl_reg[tcc_pkg::OUT_TOG1_BIT] && match1) out_next = !out_next;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            out_reg <= 1'b0;
            os_armed_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            os_armed_reg <= os_armed_next;
        end
    end

    assign TIMER_OUTPUT_PIN = outctl_reg[tcc_pkg::OUT_EN_BIT] & out_reg;
endmodule

//--- tcc_trig_src.sv
`timescale 1ns/1ps
module tcc_trig_src (
    input wire logic clk,
    input wire logic go,
    input wire logic sel,
    input wire logic [7:0] width,
    output logic pri,
    output logic sec,
    output logic busy
);
    logic [7:0] left_reg = 8'h00;
    initial pri = 1'b0;
    initial sec = 1'b0;
    assign busy = left_reg != 8'h00;
    // Toggle one line, then hold the level for the asked cycles
    always @(posedge clk) begin
        if (go && !busy) begin
            if (sel) sec <= !sec;
            else pri <= !pri;
            left_reg <= width;
        end else if (busy) begin
            left_reg <= left_reg - 8'h01;
        end
    end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin errors++; $display("FAIL %s exp %h got %h", n, e, s); end end
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic go = 1'b0, sel = 1'b0;
    logic rd_dp = 1'b0;
    logic [7:0] width = 8'h00;
    logic hrdy, hresp, pin, f1, f2, pri, sec, busy;
    logic [31:0] hrdata, r, c, e, m;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int errors = 0, cmp_count = 0, n1 = 0, n2 = 0, a1, a2, seed = 32'he3c2037e;
    tcc_timer uut (.SYS_CLK(sys_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hresp), .HRDATA(hrdata),
        .PRIMARY_TRIGGER_INPUT(pri), .SECONDARY_TRIGGER_INPUT(sec), .TIMER_OUTPUT_PIN(pin),
        .FIRST_CAPTURE_INTERRUPT(f1), .SECOND_CAPTURE_INTERRUPT(f2));
    tcc_trig_src src (.clk(sys_clk), .go(go), .sel(sel), .width(width), .pri(pri), .sec(sec), .busy(busy));
    always #12.5 sys_clk = ~sys_clk;
    // Match each read data phase with the oldest note; count interrupts
    always @(posedge sys_clk) begin
        if (rd_dp) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHK("hrdata", e, hrdata & m)
        end
        rd_dp <= hsel && htrans[1] && hrdy && !hwrite;
        n1 += f1;
        n2 += f2;
    end
    task automatic finish_test;
        $display("compared %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Bounded wait for ready at a rising edge
    task automatic step;
        int n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hrdy !== 1'b1 && n < 40);
        if (n >= 40) begin
            errors++;
            finish_test;
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        step;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        step;
        r = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
        exp_q.push_back(x & k);
        msk_q.push_back(k);
        xfer(1'b0, a, 32'h0);
    endtask
    // Toggle a trigger line, then wait until the partner is free
    task automatic tgl(input logic s, input logic [7:0] w);
        int n = 0;
        go <= 1'b1;
        sel <= s;
        width <= w;
        @(posedge sys_clk);
        go <= 1'b0;
        do @(posedge sys_clk); while (busy && ++n < 300);
        if (busy) begin
            errors++;
            finish_test;
        end
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic setup(input logic [31:0] a, input logic [31:0] b, input logic [31:0] mo, input logic [31:0] o);
        xfer(1'b1, tcc_pkg::ADDR_CC0, a);
        xfer(1'b1, tcc_pkg::ADDR_CC1, b);
        xfer(1'b1, tcc_pkg::ADDR_MODE, mo);
        xfer(1'b1, tcc_pkg::ADDR_OUTCTL, o ^ 32'h10);
        xfer(1'b1, tcc_pkg::ADDR_OUTCTL, o);
    endtask
    // Main sequence
    initial begin
        do_reset;
        for (int a = 0; a < 36; a += 4) rd(a[7:0], 32'h0, 32'hffffffff);
        c = $random(seed);
        xfer(1'b1, tcc_pkg::ADDR_CC0, c);
        rd(tcc_pkg::ADDR_CC0, {16'h0, c[15:0]}, 32'hffffffff);
        xfer(1'b1, 8'h20, c);
        rd(8'h20, 32'h0, 32'hffffffff);
        a1 = n1 + n2;
        for (int i = 0; i < 4; i++) tgl(i[1], 8'h08);
        repeat (300) @(posedge sys_clk);
        `CHK("stopped irq", a1, n1 + n2)
        rd(tcc_pkg::ADDR_MODE, 32'h0, 32'h0000000c);
        setup(32'h40, 32'h10, 32'h4, 32'h19);
        a1 = 0;
        repeat (300) @(posedge sys_clk) a1 += pin;
        `CHK("one shot", 1'b1, a1 >= 94 && a1 <= 98)
        rd(tcc_pkg::ADDR_COUNT, 32'h0, 32'h0);
        c = r;
        rd(tcc_pkg::ADDR_COUNT, 32'h0, 32'h0);
        `CHK("count moves", 1'b1, r > c)
        do_reset;
        a2 = n1;
        setup(32'h40, 32'h10, 32'hc, 32'h19);
        a1 = 0;
        repeat (300) @(posedge sys_clk) a1 += pin;
        `CHK("no one shot", 0, a1)
        `CHK("match irq", 1'b1, n1 > a2)
        do_reset;
        xfer(1'b1, tcc_pkg::ADDR_EDGE, 32'h4);
        xfer(1'b1, tcc_pkg::ADDR_CAPCTL, 32'h1);
        xfer(1'b1, tcc_pkg::ADDR_MODE, 32'h4);
        a1 = n1;
        tgl(1'b1, 8'h00);
        tgl(1'b1, 8'h00);
        repeat (100) @(posedge sys_clk);
        `CHK("noise", a1, n1)
        tgl(1'b1, 8'h08);
        tgl(1'b1, 8'h08);
        repeat (100) @(posedge sys_clk);
        `CHK("capture irq", a1 + 1, n1)
        xfer(1'b1, tcc_pkg::ADDR_MODE, 32'h0);
        xfer(1'b1, tcc_pkg::ADDR_EDGE, 32'h5);
        xfer(1'b1, tcc_pkg::ADDR_CAPCTL, 32'h7);
        xfer(1'b1, tcc_pkg::ADDR_MODE, 32'h8);
        repeat (20) @(posedge sys_clk);
        a1 = n1;
        a2 = n2;
        tgl(1'b0, 8'h08);
        tgl(1'b0, 8'h08);
        repeat (100) @(posedge sys_clk);
        `CHK("reverse irq", a1, n1)
        `CHK("second irq", a2 + 1, n2)
        tgl(1'b1, 8'h08);
        repeat (100) @(posedge sys_clk);
        `CHK("external irq", a1 + 1, n1)
        do_reset;
        xfer(1'b1, tcc_pkg::ADDR_EDGE, 32'h4);
        xfer(1'b1, tcc_pkg::ADDR_CAPCTL, 32'h1);
        a1 = n1;
        xfer(1'b1, tcc_pkg::ADDR_MODE, 32'h4);
        repeat (100) @(posedge sys_clk);
        xfer(1'b1, tcc_pkg::ADDR_MODE, 32'h0);
        xfer(1'b1, tcc_pkg::ADDR_MODE, 32'h4);
        repeat (100) @(posedge sys_clk);
        `CHK("high at enable", a1 + 1, n1)
        finish_test;
    end
endmodule
